//--- core/conv_cfg_pkg.sv
/*
 * Constants for the conversion configuration register block: offsets,
 * field positions, reset values and encodings.
 * Assumes a plain register port with one-cycle strobes on CORE_CLK.
 */
package conv_cfg_pkg;

  localparam logic [7:0] CFG_OFFSET = 8'h0C;
  localparam logic [7:0] CTRL_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_WRITABLE = 32'h7CC1_FFFF;

  localparam int DMA_EN_BIT = 0;
  localparam int DMA_CIRC_BIT = 1;
  localparam int SCAN_DIR_BIT = 2;
  localparam int RES_LSB = 3;
  localparam int ALIGN_BIT = 5;
  localparam int TRIG_SRC_LSB = 6;
  localparam int TRIG_EDGE_LSB = 10;
  localparam int OVR_POLICY_BIT = 12;
  localparam int REPEAT_BIT = 13;
  localparam int WAIT_BIT = 14;
  localparam int AUTO_OFF_BIT = 15;
  localparam int DISC_BIT = 16;
  localparam int WD_SCOPE_BIT = 22;
  localparam int WD_EN_BIT = 23;
  localparam int WD_CH_LSB = 26;

  localparam int CONV_EN_BIT = 0;
  localparam int CONV_DIS_BIT = 1;
  localparam int CONV_START_BIT = 2;
  localparam int OVR_FLAG_BIT = 4;
  localparam int WD_FLAG_BIT = 7;

  localparam logic [4:0] WD_CH_MAX = 5'h12;
  localparam logic [3:0] TRIG_SRC_MAX = 4'hE;

  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [1:0] RES_6 = 2'h3;

endpackage : conv_cfg_pkg

//--- core/conv_cfg.sv
/*
 * Conversion configuration register with the start/stop control bits,
 * the overrun and watchdog flags, trigger edge detection, result
 * shaping and overrun handling of the data register.
 * Assumes synchronous inputs, a converter that reports done, stopped
 * and watchdog events as one-cycle pulses, and a plain register port.
 */
`timescale 1ns/1ps

// Summary of operation
// (R1) config register at 0x0C, resets to all zeros
// (R2) bit 1 picks one-shot or circular dma, only with dma enabled
// (R3) bit 2 sets scan order upward or downward through slots
// (R4) bits 4:3 pick result width 12, 10, 8 or 6 bits
// (R5) bit 5 picks right or left justified result
// (R6) bits 9:6 choose one of fifteen external event inputs
// (R7) bits 11:10 arm triggering on rising, falling or both edges
// (R8) edge field zero ignores events; only software start begins conversion
// (R9) software keeps a trigger edge set in segmented sequential sampling
// (R10) bit 12 zero keeps unread result on overrun, one overwrites
// (R11) bit 13 selects single pass or continuous conversion
// (R12) bit 14 enables wait conversion mode
// (R13) bit 15 enables automatic power-off
// (R14) bit 16 enables discontinuous mode
// (R15) bit 23 enables watchdog, bit 22 picks all or one channel
// (R16) bits 30:26 name watched channel 0 to 18, other codes reserved
// (R17) software also selects the watched channel for conversion
// (R18) in segmented mode bits 30:26 report which data register holds result
// (R19) config writes accepted only while conversion start reads zero
// (R20) start settable only when enabled and not disabling; hardware clears it
// (R21) overrun sets a sticky flag cleared by writing one
// (R22) watchdog event sets a sticky flag cleared by writing one
// (R23) blocked writes change nothing; reserved bits read zero
// (R24) bit 0 lets results raise dma requests
module conv_cfg
  import conv_cfg_pkg::*;
#(
  parameter int RESULT_W = 12,
  parameter int EVENTS = 15
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [EVENTS-1:0] HW_EVENTS,
  input wire logic CONV_DONE,
  input wire logic [RESULT_W-1:0] CONV_RESULT,
  input wire logic CONV_STOPPED,
  input wire logic WD_EVENT,
  input wire logic SEG_MODE,
  input wire logic SEG_STORE,
  input wire logic [4:0] SEG_REG_INDEX,
  input wire logic DATA_READ,
  output logic [15:0] DATA_OUT,
  output logic DMA_REQ,
  output logic DMA_CIRCULAR,
  output logic SCAN_DOWN,
  output logic CONV_START,
  output logic CONTINUOUS,
  output logic WAIT_MODE,
  output logic AUTO_OFF,
  output logic DISCONTINUOUS,
  output logic WD_ENABLE,
  output logic WD_SINGLE,
  output logic [4:0] WD_CHANNEL
);

  logic [31:0] cfg_ff;
  logic conv_en_ff;
  logic conv_dis_ff;
  logic start_ff;
  logic ovr_flag_ff;
  logic wd_flag_ff;
  logic data_valid_ff;
  logic [15:0] data_ff;
  logic [EVENTS-1:0] evt_prev_ff;
  logic [31:0] nxt_rdata;
  logic [15:0] shaped;
  logic [RESULT_W-1:0] masked;
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_status;
  logic trig_pulse;
  logic sel_now;
  logic sel_prev;
  logic overrun;

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  assign wr_cfg = WR && (ADDR == CFG_OFFSET);
  assign wr_ctrl = WR && (ADDR == CTRL_OFFSET);
  assign wr_status = WR && (ADDR == STATUS_OFFSET);

  // reserved bits never stored, so they read zero
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cfg_ff <= CFG_RESET; // R1
    end else if (wr_cfg && !start_ff) begin // R19 R23
      cfg_ff <= WDATA & CFG_WRITABLE; // R23
    end else if (SEG_MODE && SEG_STORE) begin
      // segmented mode reuses the channel field as a result pointer
      cfg_ff[WD_CH_LSB +: 5] <= SEG_REG_INDEX; // R18
    end
  end

  // ------------------------------------------------------------
  // enable, disable and start control
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      conv_en_ff <= 1'b0;
    end else if (wr_ctrl && WDATA[CONV_EN_BIT] && !conv_en_ff) begin
      conv_en_ff <= 1'b1;
    end else if (conv_dis_ff && !start_ff) begin
      conv_en_ff <= 1'b0;
    end
  end

  // disable stays set until the enable has dropped, so it reads back meanwhile
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      conv_dis_ff <= 1'b0;
    end else if (wr_ctrl && WDATA[CONV_DIS_BIT] && conv_en_ff && !start_ff) begin
      conv_dis_ff <= 1'b1;
    end else if (!conv_en_ff) begin
      conv_dis_ff <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      start_ff <= 1'b0;
    end else if (wr_ctrl && WDATA[CONV_START_BIT] && conv_en_ff && !conv_dis_ff) begin
      start_ff <= 1'b1; // R20
    end else if (CONV_STOPPED) begin
      start_ff <= 1'b0; // R20
    end
  end

  // ------------------------------------------------------------
  // hardware trigger edge detection
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      evt_prev_ff <= '0;
    end else begin
      evt_prev_ff <= HW_EVENTS;
    end
  end

  // out-of-range source codes select no event
  always_comb begin
    sel_now = 1'b0;
    sel_prev = 1'b0;
    if (cfg_ff[TRIG_SRC_LSB +: 4] <= TRIG_SRC_MAX) begin // R6
      sel_now = HW_EVENTS[cfg_ff[TRIG_SRC_LSB +: 4]];
      sel_prev = evt_prev_ff[cfg_ff[TRIG_SRC_LSB +: 4]];
    end
  end

  always_comb begin
    unique case (cfg_ff[TRIG_EDGE_LSB +: 2])
      EDGE_OFF: trig_pulse = 1'b0; // R8
      EDGE_RISE: trig_pulse = sel_now && !sel_prev; // R7
      EDGE_FALL: trig_pulse = !sel_now && sel_prev; // R7
      EDGE_BOTH: trig_pulse = sel_now != sel_prev; // R7
    endcase
  end

  // conversion runs only when started and, if armed, triggered
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      CONV_START <= 1'b0;
    end else if (cfg_ff[TRIG_EDGE_LSB +: 2] == EDGE_OFF) begin
      CONV_START <= wr_ctrl && WDATA[CONV_START_BIT] && conv_en_ff && !conv_dis_ff; // R8
    end else begin
      CONV_START <= start_ff && trig_pulse; // R7
    end
  end

  // ------------------------------------------------------------
  // result shaping and data register
  // ------------------------------------------------------------
  always_comb begin
    masked = CONV_RESULT;
    unique case (cfg_ff[RES_LSB +: 2]) // R4
      RES_12: masked = CONV_RESULT;
      RES_10: masked = {CONV_RESULT[RESULT_W-1:2], 2'h0};
      RES_8: masked = {CONV_RESULT[RESULT_W-1:4], 4'h0};
      RES_6: masked = {CONV_RESULT[RESULT_W-1:6], 6'h0};
    endcase
    if (cfg_ff[ALIGN_BIT]) begin // R5
      shaped = {masked, {(16 - RESULT_W){1'b0}}};
    end else begin
      unique case (cfg_ff[RES_LSB +: 2])
        RES_12: shaped = 16'(masked);
        RES_10: shaped = 16'(masked >> 2);
        RES_8: shaped = 16'(masked >> 4);
        RES_6: shaped = 16'(masked >> 6);
      endcase
    end
  end

  assign overrun = CONV_DONE && data_valid_ff && !DATA_READ;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      data_ff <= 16'h0000;
    end else if (CONV_DONE && (!overrun || cfg_ff[OVR_POLICY_BIT])) begin // R10
      data_ff <= shaped;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      data_valid_ff <= 1'b0;
    end else if (CONV_DONE) begin
      data_valid_ff <= 1'b1;
    end else if (DATA_READ) begin
      data_valid_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // sticky flags: a set in the clearing cycle wins
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ovr_flag_ff <= 1'b0;
    end else if (overrun) begin
      ovr_flag_ff <= 1'b1; // R21
    end else if (wr_status && WDATA[OVR_FLAG_BIT]) begin
      ovr_flag_ff <= 1'b0; // R21
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wd_flag_ff <= 1'b0;
    end else if (WD_EVENT && cfg_ff[WD_EN_BIT]) begin
      wd_flag_ff <= 1'b1; // R22
    end else if (wr_status && WDATA[WD_FLAG_BIT]) begin
      wd_flag_ff <= 1'b0; // R22
    end
  end

  // ------------------------------------------------------------
  // data output and dma request
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DATA_OUT <= 16'h0000;
    end else begin
      DATA_OUT <= data_ff;
    end
  end

  // a kept result on overrun still raises a request; dma then sees the old word
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DMA_REQ <= 1'b0;
    end else begin
      DMA_REQ <= CONV_DONE && cfg_ff[DMA_EN_BIT]; // R24
    end
  end

  // circular has no meaning without dma, so it is masked here
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DMA_CIRCULAR <= 1'b0;
    end else begin
      DMA_CIRCULAR <= cfg_ff[DMA_EN_BIT] && cfg_ff[DMA_CIRC_BIT]; // R2
    end
  end

  // ------------------------------------------------------------
  // configuration mirrors
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SCAN_DOWN <= 1'b0;
      CONTINUOUS <= 1'b0;
      WAIT_MODE <= 1'b0;
      AUTO_OFF <= 1'b0;
      DISCONTINUOUS <= 1'b0;
    end else begin
      SCAN_DOWN <= cfg_ff[SCAN_DIR_BIT]; // R3
      CONTINUOUS <= cfg_ff[REPEAT_BIT]; // R11
      WAIT_MODE <= cfg_ff[WAIT_BIT]; // R12
      AUTO_OFF <= cfg_ff[AUTO_OFF_BIT]; // R13
      DISCONTINUOUS <= cfg_ff[DISC_BIT]; // R14
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      WD_ENABLE <= 1'b0;
      WD_SINGLE <= 1'b0;
      WD_CHANNEL <= 5'h00;
    end else begin
      WD_ENABLE <= cfg_ff[WD_EN_BIT]; // R15
      WD_SINGLE <= cfg_ff[WD_SCOPE_BIT]; // R15
      // reserved channel codes disable single-channel matching
      WD_CHANNEL <= (cfg_ff[WD_CH_LSB +: 5] <= WD_CH_MAX) ?
        cfg_ff[WD_CH_LSB +: 5] : 5'h1F; // R16
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (ADDR)
      CFG_OFFSET: nxt_rdata = cfg_ff;
      CTRL_OFFSET: begin
        nxt_rdata[CONV_EN_BIT] = conv_en_ff;
        nxt_rdata[CONV_DIS_BIT] = conv_dis_ff;
        nxt_rdata[CONV_START_BIT] = start_ff;
      end
      STATUS_OFFSET: begin
        nxt_rdata[OVR_FLAG_BIT] = ovr_flag_ff;
        nxt_rdata[WD_FLAG_BIT] = wd_flag_ff;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= nxt_rdata;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

endmodule : conv_cfg

//--- sim/conv_cfg_checker.sv
/* checker: port assertions for conv_cfg
   assumes CORE_CLK, RST async high, bound below */
`timescale 1ns/1ps
module conv_cfg_checker
  import conv_cfg_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic CONV_DONE,
  input wire logic DMA_REQ,
  input wire logic DMA_CIRCULAR,
  input wire logic SCAN_DOWN,
  input wire logic CONTINUOUS,
  input wire logic WAIT_MODE,
  input wire logic AUTO_OFF,
  input wire logic DISCONTINUOUS,
  input wire logic WD_ENABLE,
  input wire logic WD_SINGLE,
  input wire logic [4:0] WD_CHANNEL
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // read data and mirrors come from the same cfg value
  logic cfg_rd_ff;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) cfg_rd_ff <= 1'b0;
    else cfg_rd_ff <= RD && ADDR == CFG_OFFSET;
  end
  AST_UNMAPPED: assert property (RD && ADDR == 8'h40 |=> RDATA == '0)
    else $error("unmapped read not zero");
  AST_RESERVED: assert property (cfg_rd_ff |-> (RDATA & ~CFG_WRITABLE) == '0)
    else $error("reserved bits read nonzero");
  AST_DMA_CIRC: assert property (cfg_rd_ff |-> DMA_CIRCULAR == (RDATA[0] & RDATA[1]))
    else $error("circular dma mismatch");
  AST_SCAN: assert property (cfg_rd_ff |-> SCAN_DOWN == RDATA[2])
    else $error("scan direction mismatch");
  AST_MODES: assert property (cfg_rd_ff |->
    {DISCONTINUOUS, AUTO_OFF, WAIT_MODE, CONTINUOUS} == RDATA[16:13])
    else $error("mode bits mismatch");
  AST_WD: assert property (cfg_rd_ff |-> {WD_ENABLE, WD_SINGLE} == RDATA[23:22])
    else $error("watchdog bits mismatch");
  AST_WD_CH: assert property (cfg_rd_ff |->
    WD_CHANNEL == (RDATA[30:26] > WD_CH_MAX ? 5'h1F : RDATA[30:26]))
    else $error("watchdog channel mismatch");
  AST_DMA_REQ: assert property (DMA_REQ |-> $past(CONV_DONE))
    else $error("dma request without result");
endmodule : conv_cfg_checker

bind conv_cfg conv_cfg_checker conv_cfg_checker_i (.CORE_CLK(CORE_CLK), .RST(RST),
  .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .CONV_DONE(CONV_DONE), .DMA_REQ(DMA_REQ),
  .DMA_CIRCULAR(DMA_CIRCULAR), .SCAN_DOWN(SCAN_DOWN), .CONTINUOUS(CONTINUOUS),
  .WAIT_MODE(WAIT_MODE), .AUTO_OFF(AUTO_OFF), .DISCONTINUOUS(DISCONTINUOUS),
  .WD_ENABLE(WD_ENABLE), .WD_SINGLE(WD_SINGLE), .WD_CHANNEL(WD_CHANNEL));

//--- sim/conv_cfg_bench.sv
/* bench: register port scenarios for conv_cfg
   assumes package and checker compiled first */
`timescale 1ns/1ps
module conv_cfg_bench;
  import conv_cfg_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, done = 0, stop = 0, wde = 0;
  logic dr = 0, sm = 0, ss = 0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [14:0] ev = '0;
  logic [11:0] res = '0;
  logic [4:0] si = '0, wch;
  logic [15:0] dout;
  logic dreq, dcirc, sdown, cstart, cont, waitm, aoff, disc, wden, wdsing;
  int fails = 0, n_checks = 0;
  always #25 clk = ~clk;
  conv_cfg conv_cfg_i (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .HW_EVENTS(ev), .CONV_DONE(done), .CONV_RESULT(res),
    .CONV_STOPPED(stop), .WD_EVENT(wde), .SEG_MODE(sm), .SEG_STORE(ss), .SEG_REG_INDEX(si),
    .DATA_READ(dr), .DATA_OUT(dout), .DMA_REQ(dreq), .DMA_CIRCULAR(dcirc),
    .SCAN_DOWN(sdown), .CONV_START(cstart), .CONTINUOUS(cont), .WAIT_MODE(waitm),
    .AUTO_OFF(aoff), .DISCONTINUOUS(disc), .WD_ENABLE(wden), .WD_SINGLE(wdsing),
    .WD_CHANNEL(wch));
  // ----------
  // bus tasks
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask : rdc
  // k: 0 result done, 1 stopped, 2 watchdog hit
  task automatic pls(input int k);
    @(posedge clk);
    {wde, stop, done} <= 3'(1 << k);
    @(posedge clk);
    {wde, stop, done} <= '0;
    #1;
  endtask : pls
  // ----------
  // scenarios
  // ----------
  task automatic t_reset;
    rdc("cfg", CFG_OFFSET, CFG_RESET);
    chk("outs", {dreq, dcirc, sdown, cstart, cont, waitm, aoff, disc, wden, wdsing, wch, dout},
      '0);
    rdc("unmapped", 8'h40, '0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields;
    logic [31:0] d;
    wrr(CFG_OFFSET, 32'hFFFF_FFFF);
    rdc("cfg all", CFG_OFFSET, CFG_WRITABLE);
    chk("circ", dcirc, 1);
    chk("modes", {sdown, cont, waitm, aoff, disc, wden, wdsing}, 7'h7F);
    chk("wd ch reserved", wch, 5'h1F);
    wrr(CFG_OFFSET, 32'h4800_0002);
    rdc("cfg ch18", CFG_OFFSET, 32'h4800_0002);
    chk("circ no dma", dcirc, 0);
    chk("wd ch", wch, 5'h12);
    for (int i = 0; i < 4; i++) begin
      d = (i << 3) | (i << 10) | ((14 - i) << 6) | ((i % 2) << 5);
      wrr(CFG_OFFSET, d);
      rdc("res edge src", CFG_OFFSET, d);
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_lock;
    wrr(CFG_OFFSET, 32'h0000_2000);
    wrr(CTRL_OFFSET, 32'h1);
    wrr(CTRL_OFFSET, 32'h4);
    // the start pulse stands only in the cycle after the write edge
    #1 chk("sw start", cstart, 1);
    wrr(CFG_OFFSET, 32'h4);
    rdc("cfg locked", CFG_OFFSET, 32'h2000);
    pls(1);
    rdc("ctrl", CTRL_OFFSET, 32'h1);
    wrr(CFG_OFFSET, 32'h4);
    rdc("cfg open", CFG_OFFSET, 32'h4);
    $display("test lock done");
  endtask : t_lock
  task automatic t_flags;
    wrr(CFG_OFFSET, 32'h0080_0001);
    pls(0);
    chk("dma req", dreq, 1);
    pls(0);
    pls(2);
    rdc("flags set", STATUS_OFFSET, 32'h90);
    wrr(STATUS_OFFSET, 32'h90);
    rdc("flags clear", STATUS_OFFSET, 32'h0);
    wrr(CFG_OFFSET, 32'h0);
    pls(0);
    chk("no dma req", dreq, 0);
    $display("test flags done");
  endtask : t_flags
  task automatic cnv(input logic [11:0] r);
    @(posedge clk);
    res <= r;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    #1;
  endtask : cnv
  task automatic evt(input logic [14:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    #1;
  endtask : evt
  task automatic t_shape;
    logic [15:0] rt [4];
    logic [15:0] lt [4];
    rt = '{16'h0ABD, 16'h02AF, 16'h00AB, 16'h002A};
    lt = '{16'hABD0, 16'hABC0, 16'hAB00, 16'hA800};
    for (int i = 0; i < 4; i++) begin
      wrr(CFG_OFFSET, 32'h1000 | (i << 3));
      cnv(12'hABD);
      @(posedge clk);
      #1 chk("right", dout, rt[i]);
      wrr(CFG_OFFSET, 32'h1020 | (i << 3));
      cnv(12'hABD);
      @(posedge clk);
      #1 chk("left", dout, lt[i]);
    end
    $display("test shape done");
  endtask : t_shape
  task automatic t_overrun;
    wrr(CFG_OFFSET, 32'h0);
    wrr(STATUS_OFFSET, 32'h90);
    @(posedge clk);
    dr <= 1'b1;
    @(posedge clk);
    dr <= 1'b0;
    cnv(12'h123);
    cnv(12'h456);
    @(posedge clk);
    #1 chk("keep old", dout, 16'h0123);
    rdc("ovr flag", STATUS_OFFSET, 32'h10);
    $display("test overrun done");
  endtask : t_overrun
  task automatic t_trig;
    wrr(CFG_OFFSET, 32'h0540);
    wrr(CTRL_OFFSET, 32'h4);
    #1 chk("armed sw start", cstart, 0);
    evt(15'h0010);
    chk("other source", cstart, 0);
    evt(15'h0030);
    chk("rising", cstart, 1);
    evt(15'h0010);
    chk("falling ignored", cstart, 0);
    pls(1);
    wrr(CFG_OFFSET, 32'h0D40);
    wrr(CTRL_OFFSET, 32'h4);
    evt(15'h0030);
    chk("both rise", cstart, 1);
    evt(15'h0000);
    chk("both fall", cstart, 1);
    pls(1);
    $display("test trig done");
  endtask : t_trig
  task automatic t_seg;
    wrr(CFG_OFFSET, 32'h0400);
    @(posedge clk);
    sm <= 1'b1;
    ss <= 1'b1;
    si <= 5'h07;
    @(posedge clk);
    sm <= 1'b0;
    ss <= 1'b0;
    rdc("seg index", CFG_OFFSET, 32'h1C00_0400);
    chk("seg channel", wch, 5'h07);
    $display("test seg done");
  endtask : t_seg
  task automatic test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_lock();
    t_flags();
    t_shape();
    t_overrun();
    t_trig();
    t_seg();
    test_done();
  end
  // whole run is near 160 cycles
  initial begin
    #50000;
    fails++;
    test_done();
  end
endmodule : conv_cfg_bench
